/* File: hw/hcp_pin_if.sv */
// Purpose: Synchronised host pin levels passed to the port core.
// Assumes: Driven by the pin synchroniser only.
// Notes: Shared pin sio is serial input, read/write or write strobe.
`timescale 1ns/1ps
`default_nettype none
interface hcp_pin_if;
  import hcp_pkg::*;
  logic              cs_n;
  logic              sclk;
  logic              sio;
  logic              strb_n;
  logic              edge_sel;
  logic              par_sel;
  logic              style_sel;
  logic              rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  modport src (output cs_n, sclk, sio, strb_n, edge_sel, par_sel, style_sel, rst_n, addr, data);
  modport dst (input cs_n, sclk, sio, strb_n, edge_sel, par_sel, style_sel, rst_n, addr, data);
endinterface : hcp_pin_if
`default_nettype wire

/* File: hw/hcp_pin_sync.sv */
// Purpose: Two-flop synchroniser for every host pin.
// Assumes: Pins are asynchronous; bus skew settles within a strobe.
// Notes: Only the second stage is published.
`timescale 1ns/1ps
`default_nettype none
module hcp_pin_sync
  import hcp_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  input  wire logic [PIN_W-1:0] pins_i,
  hcp_pin_if.src                pin
);
  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] meta_nxt;
  logic [PIN_W-1:0] q_r;
  logic [PIN_W-1:0] q_nxt;

  // First stage feeds only the second
  always_comb
  begin
    meta_nxt = pins_i;
    q_nxt    = meta_r;
  end

  // Idle levels keep strobes inactive out of reset
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      meta_r <= PIN_IDLE;
      q_r    <= PIN_IDLE;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  // Unpack the bundle
  assign pin.cs_n      = q_r[PIN_CS];
  assign pin.sclk      = q_r[PIN_SCLK];
  assign pin.sio       = q_r[PIN_SIO];
  assign pin.strb_n    = q_r[PIN_STRB];
  assign pin.edge_sel  = q_r[PIN_EDGE];
  assign pin.par_sel   = q_r[PIN_PAR];
  assign pin.style_sel = q_r[PIN_STYLE];
  assign pin.rst_n     = q_r[PIN_RST];
  assign pin.addr      = q_r[PIN_ADDR +: ADDR_W];
  assign pin.data      = q_r[PIN_DATA +: DATA_W];
endmodule : hcp_pin_sync
`default_nettype wire

/* File: hw/hcp_pkg.sv */
// Purpose: Shared constants and types for the host control port.
// Assumes: 100 MHz core clock; all host pins asynchronous to it.
// Notes: Pin vector positions describe the synchroniser bundle.
// Function
// - Select low chooses the serial port.
// - Parallel port uses address, data, two strobes; data-strobe style has one strobe and a read/write line.
// - Select/style 10 data-strobe, 11 separate strobes.
// - Respond only while chip select is low.
// - Serial input sampled on shift clock rise.
// - Serial output on rise or fall per select.
// - Data-strobe style: write captures, read drives.
// - Read strobe low makes device drive data.
// - Write strobe low, device captures data bus.
// - Reset pin low over 100ns resets all.
package hcp_pkg;
  // Timing
  localparam int         CLK_MHZ     = 100;
  localparam int         RST_MIN_NS  = 100;
  localparam int         RST_CYC_INT = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] RST_CYC     = 4'(RST_CYC_INT);
  // Bus widths
  localparam int         ADDR_W = 8;
  localparam int         DATA_W = 8;
  // Serial frame: read/write bit, address LSB first, data LSB first
  localparam logic [4:0] SER_ADDR_LAST = 5'h08;
  localparam logic [4:0] SER_DATA_LAST = 5'h10;
  localparam logic [4:0] SER_DONE      = 5'h11;
  // Synchroniser bundle layout
  localparam int PIN_CS    = 0;
  localparam int PIN_SCLK  = 1;
  localparam int PIN_SIO   = 2;
  localparam int PIN_STRB  = 3;
  localparam int PIN_EDGE  = 4;
  localparam int PIN_PAR   = 5;
  localparam int PIN_STYLE = 6;
  localparam int PIN_RST   = 7;
  localparam int PIN_ADDR  = 8;
  localparam int PIN_DATA  = 16;
  localparam int PIN_W     = 24;
  localparam logic [PIN_W-1:0] PIN_IDLE = 24'h00008D;
  typedef enum logic [1:0] {HCP_SER, HCP_PAR_DS, HCP_PAR_RW} hcp_mode_e;
endpackage : hcp_pkg

/* File: hw/hcp_port.sv */
// Purpose: Host control port: serial or parallel access to a register file.
// Assumes: reg_rdata_i answers reg_addr_o combinationally.
// Notes: All host pins are oversampled; shift clock must stay well below core clock.
`timescale 1ns/1ps
`default_nettype none
module hcp_port
  import hcp_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              hw_rst_n_i,
  input  wire logic              cs_n_i,
  input  wire logic              sclk_i,
  input  wire logic              serial_in_line_i,
  input  wire logic              strobe_or_read_n_i,
  input  wire logic              output_edge_select_i,
  input  wire logic              port_par_sel_i,
  input  wire logic              strobe_style_select_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   data_oe_n_o,
  output logic                   serial_out_line_o,
  output logic                   serial_out_oe_n_o,
  output logic      [ADDR_W-1:0] reg_addr_o,
  output logic      [DATA_W-1:0] reg_wdata_o,
  output logic                   reg_wr_o,
  output logic                   reg_rd_o,
  input  wire logic [DATA_W-1:0] reg_rdata_i,
  output var hcp_mode_e          port_mode_o
);
  hcp_pin_if p ();

  hcp_pin_sync u_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .pins_i     ({data_i, addr_i, hw_rst_n_i, strobe_style_select_i, port_par_sel_i,
                  output_edge_select_i, strobe_or_read_n_i, serial_in_line_i, sclk_i, cs_n_i}),
    .pin        (p.src)
  );

  logic [3:0]        rcnt_r;
  logic [3:0]        rcnt_nxt;
  logic              rst_hit_r;
  logic              rst_hit_nxt;
  logic              core_rst;
  hcp_mode_e         mode_r;
  hcp_mode_e         mode_nxt;
  logic              sclk_d_r;
  logic              sclk_d_nxt;
  logic              cs_act;
  logic              rise;
  logic              fall;
  logic              out_edge;
  logic              rd_act;
  logic              wr_act;
  logic [4:0]        bcnt_r;
  logic [4:0]        bcnt_nxt;
  logic [7:0]        sh_r;
  logic [7:0]        sh_nxt;
  logic              rw_r;
  logic              rw_nxt;
  logic [DATA_W-1:0] sout_r;
  logic [DATA_W-1:0] sout_nxt;
  logic              sdo_r;
  logic              sdo_nxt;
  logic              sdo_oe_n_r;
  logic              sdo_oe_n_nxt;
  logic [DATA_W-1:0] dlat_r;
  logic [DATA_W-1:0] dlat_nxt;
  logic              rd_act_r;
  logic              wr_act_r;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] wdata_nxt;
  logic              wr_r;
  logic              wr_nxt;
  logic              rd_r;
  logic              rd_nxt;
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] dout_nxt;
  logic              doe_n_r;
  logic              doe_n_nxt;

  // Pin reset filter: a glitch shorter than the minimum is ignored
  always_comb
  begin
    rcnt_nxt    = rcnt_r;
    rst_hit_nxt = 1'b0;
    if (p.rst_n)
      rcnt_nxt = 4'h0;
    else if (rcnt_r != RST_CYC)
      rcnt_nxt = rcnt_r + 4'h1;
    if (!p.rst_n && rcnt_r == RST_CYC)
      rst_hit_nxt = 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      rcnt_r    <= 4'h0;
      rst_hit_r <= 1'b0;
    end
    else
    begin
      rcnt_r    <= rcnt_nxt;
      rst_hit_r <= rst_hit_nxt;
    end
  end

  assign core_rst = !nrst_i || rst_hit_r;
  assign cs_act   = !p.cs_n;
  assign rise     = p.sclk && !sclk_d_r;
  assign fall     = !p.sclk && sclk_d_r;
  assign out_edge = p.edge_sel ? fall : rise;

  // Straps are only taken while deselected, so a frame never sees a mode change
  always_comb
  begin
    mode_nxt   = mode_r;
    sclk_d_nxt = p.sclk;
    if (p.cs_n)
    begin
      if (!p.par_sel)
        mode_nxt = HCP_SER;
      else if (p.style_sel)
        mode_nxt = HCP_PAR_RW;
      else
        mode_nxt = HCP_PAR_DS;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (core_rst)
    begin
      mode_r   <= HCP_SER;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      mode_r   <= mode_nxt;
      sclk_d_r <= sclk_d_nxt;
    end
  end

  // Parallel strobe decode; read wins if both strobes are low
  always_comb
  begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    unique case (mode_r)
      HCP_PAR_DS:
      begin
        rd_act = cs_act && !p.strb_n && p.sio;
        wr_act = cs_act && !p.strb_n && !p.sio;
      end
      HCP_PAR_RW:
      begin
        rd_act = cs_act && !p.strb_n;
        wr_act = cs_act && !p.sio && p.strb_n;
      end
      HCP_SER:
      begin
        rd_act = 1'b0;
        wr_act = 1'b0;
      end
    endcase
  end

  // Transfer engine for both ports
  always_comb
  begin
    bcnt_nxt     = bcnt_r;
    sh_nxt       = sh_r;
    rw_nxt       = rw_r;
    sout_nxt     = sout_r;
    sdo_nxt      = sdo_r;
    sdo_oe_n_nxt = sdo_oe_n_r;
    dlat_nxt     = dlat_r;
    addr_nxt     = addr_r;
    wdata_nxt    = wdata_r;
    wr_nxt       = 1'b0;
    rd_nxt       = 1'b0;
    dout_nxt     = dout_r;
    if (!cs_act)
    begin
      bcnt_nxt     = 5'h00;
      sdo_oe_n_nxt = 1'b1;
    end
    else if (mode_r == HCP_SER)
    begin
      if (rise && bcnt_r != SER_DONE)
      begin
        bcnt_nxt = bcnt_r + 5'h01;
        sh_nxt   = {p.sio, sh_r[7:1]};
        if (bcnt_r == 5'h00)
          rw_nxt = p.sio;
        if (bcnt_r == SER_ADDR_LAST)
        begin
          addr_nxt = {p.sio, sh_r[7:1]};
          rd_nxt   = rw_r;
        end
        if (bcnt_r == SER_DATA_LAST && !rw_r)
        begin
          wdata_nxt = {p.sio, sh_r[7:1]};
          wr_nxt    = 1'b1;
        end
      end
      // Drive only after the address is complete on a read
      if (rw_r && bcnt_r > SER_ADDR_LAST)
      begin
        sdo_oe_n_nxt = 1'b0;
        if (out_edge)
        begin
          sdo_nxt  = sout_r[0];
          sout_nxt = {1'b0, sout_r[DATA_W-1:1]};
        end
      end
      if (rd_r)
        sout_nxt = reg_rdata_i;
    end
    // Parallel side; a write address follows the pins while the write is active, a read address is taken on the read's first cycle
    if (wr_act)
    begin
      dlat_nxt = p.data;
      addr_nxt = p.addr;
    end
    if (rd_act && !rd_act_r)
    begin
      addr_nxt = p.addr;
      rd_nxt   = 1'b1;
    end
    if (wr_act_r && !wr_act)
    begin
      wdata_nxt = dlat_r;
      wr_nxt    = 1'b1;
    end
    if (rd_act_r)
      dout_nxt = reg_rdata_i;
    doe_n_nxt = !(rd_act && rd_act_r);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (core_rst)
    begin
      bcnt_r     <= 5'h00;
      sh_r       <= 8'h00;
      rw_r       <= 1'b0;
      sout_r     <= 8'h00;
      sdo_r      <= 1'b0;
      sdo_oe_n_r <= 1'b1;
      dlat_r     <= 8'h00;
      rd_act_r   <= 1'b0;
      wr_act_r   <= 1'b0;
      addr_r     <= 8'h00;
      wdata_r    <= 8'h00;
      wr_r       <= 1'b0;
      rd_r       <= 1'b0;
      dout_r     <= 8'h00;
      doe_n_r    <= 1'b1;
    end
    else
    begin
      bcnt_r     <= bcnt_nxt;
      sh_r       <= sh_nxt;
      rw_r       <= rw_nxt;
      sout_r     <= sout_nxt;
      sdo_r      <= sdo_nxt;
      sdo_oe_n_r <= sdo_oe_n_nxt;
      dlat_r     <= dlat_nxt;
      rd_act_r   <= rd_act;
      wr_act_r   <= wr_act;
      addr_r     <= addr_nxt;
      wdata_r    <= wdata_nxt;
      wr_r       <= wr_nxt;
      rd_r       <= rd_nxt;
      dout_r     <= dout_nxt;
      doe_n_r    <= doe_n_nxt;
    end
  end

  // Outputs straight from flops
  assign data_o            = dout_r;
  assign data_oe_n_o       = doe_n_r;
  assign serial_out_line_o = sdo_r;
  assign serial_out_oe_n_o = sdo_oe_n_r;
  assign reg_addr_o        = addr_r;
  assign reg_wdata_o       = wdata_r;
  assign reg_wr_o          = wr_r;
  assign reg_rd_o          = rd_r;
  assign port_mode_o       = mode_r;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (core_rst);

  sequence s_wr_end;
    (mode_r != HCP_SER) && wr_act_r && !wr_act;
  endsequence
  sequence s_rd_hold;
    rd_act ##1 rd_act;
  endsequence
  sequence s_rst_long;
    (rcnt_r == RST_CYC) && !p.rst_n;
  endsequence

  AST_CS_IDLE: assert property (p.cs_n |=> data_oe_n_o && serial_out_oe_n_o)
    else $error("outputs driven while deselected");
  AST_CS_ONLY: assert property (!serial_out_oe_n_o |-> $past(cs_act))
    else $error("serial output driven without chip select");
  AST_SER_NO_D: assert property (mode_r == HCP_SER |-> data_oe_n_o)
    else $error("data bus driven in serial mode");
  AST_PAR_NO_SDO: assert property (mode_r != HCP_SER |-> serial_out_oe_n_o)
    else $error("serial output driven in parallel mode");
  AST_DECODE: assert property (p.cs_n && p.par_sel && p.style_sel |=> mode_r == HCP_PAR_RW)
    else $error("style 11 not decoded");
  AST_STRAP_HOLD: assert property (cs_act |=> $stable(mode_r))
    else $error("mode changed during a transfer");
  AST_SDI_COUNT: assert property (cs_act && mode_r == HCP_SER && rise && bcnt_r < SER_DONE
                                  |=> bcnt_r == $past(bcnt_r) + 5'h01)
    else $error("shift clock rise not counted");
  AST_SDO_EDGE: assert property ($changed(serial_out_line_o) |-> $past(out_edge))
    else $error("serial output moved off its edge");
  AST_WR_CAPTURE: assert property (s_wr_end |=> reg_wr_o && reg_wdata_o == $past(dlat_r))
    else $error("write strobe end not captured");
  AST_RD_DRIVE: assert property (s_rd_hold |=> !data_oe_n_o && data_o == $past(reg_rdata_i))
    else $error("read data not driven");
  AST_HW_RST: assert property (disable iff (!nrst_i) s_rst_long |=> rst_hit_r
                               ##1 (data_oe_n_o && serial_out_oe_n_o && !reg_wr_o))
    else $error("long reset pulse not honoured");
endmodule : hcp_port
`default_nettype wire

/* File: verif/hcp_host_model.sv */
// Purpose: Host microcontroller model that drives the control port pins.
// Assumes: Tasks are called just after a falling core clock edge.
// Notes: Shift clock is 80 ns and rests low outside frames.
`timescale 1ns/1ps
`default_nettype none
module hcp_host_model
  import hcp_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              style_i,
  input  wire logic [DATA_W-1:0] bus_i,
  input  wire logic              oe_n_i,
  input  wire logic              sdo_i,
  output var  logic              cs_n_o,
  output var  logic              sclk_o,
  output var  logic              sio_o,
  output var  logic              strb_n_o,
  output var  logic [ADDR_W-1:0] addr_o,
  output var  logic [DATA_W-1:0] data_o
);
  // Idle pins at time zero
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sio_o = 1'b1;
    strb_n_o = 1'b1;
    addr_o = 8'h00;
    data_o = 8'hFF;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : wait_n

  // Serial frame; samples output just before its next change edge
  task automatic ser(input logic rd, input logic es, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [16:0] bits;
    bits = {d, a, rd};
    q = 8'h00;
    cs_n_o = 1'b0;
    wait_n(4);
    for (int k = 0; k < 17; k++)
    begin
      sio_o = bits[k];
      wait_n(4);
      if (!es && k >= 10) q[k-10] = sdo_i;
      sclk_o = 1'b1;
      wait_n(4);
      if (es && k >= 9) q[k-9] = sdo_i;
      sclk_o = 1'b0;
    end
    wait_n(4);
    if (!es) q[7] = sdo_i;
    sio_o = ~sio_o; // Released line shows no stale bit
    cs_n_o = 1'b1;
    wait_n(5);
  endtask : ser

  // Parallel access in either strobe style
  task automatic par(input logic rd, input logic cs_en, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic oe_n);
    addr_o = a;
    data_o = d;
    cs_n_o = !cs_en;
    if (!style_i) sio_o = rd;
    wait_n(3);
    if (style_i && !rd) sio_o = 1'b0;
    else strb_n_o = 1'b0;
    wait_n(8);
    q = bus_i;
    oe_n = oe_n_i;
    strb_n_o = 1'b1;
    sio_o = 1'b1;
    wait_n(3);
    cs_n_o = 1'b1;
    data_o = ~d;
    wait_n(5);
  endtask : par
endmodule : hcp_host_model
`default_nettype wire

/* File: verif/host_control_port_select_tb.sv */
// Purpose: Self-checking bench for the host control port.
// Assumes: Register file answers address xor A5 combinationally.
// Notes: Accesses note their expected register strobe in a queue.
`timescale 1ns/1ps
`default_nettype none
module host_control_port_select_tb;
  import hcp_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d;} hcp_note_s;
  localparam int WATCH_NS = 60000; // Tests need about 11 us
  logic              core_clk_i = 1'b0, nrst_i = 1'b0, hw_rst_n_i = 1'b1;
  logic              output_edge_select_i = 1'b0;
  logic              port_par_sel_i = 1'b0, strobe_style_select_i = 1'b0;
  logic              cs_n_i, sclk_i, serial_in_line_i, strobe_or_read_n_i;
  logic [ADDR_W-1:0] addr_i, reg_addr_o;
  logic [DATA_W-1:0] data_i, host_d, data_o, reg_wdata_o, reg_rdata_i;
  logic              data_oe_n_o, serial_out_line_o, serial_out_oe_n_o, reg_wr_o, reg_rd_o;
  hcp_mode_e         port_mode_o;
  hcp_note_s         notes[$], n, got_n;
  logic [31:0]       seed = 32'h8A555F64;
  int                bad_count = 0, checked = 0;

  // Shared data wire and register file
  assign data_i = (data_oe_n_o === 1'b0) ? data_o : host_d;
  assign reg_rdata_i = reg_addr_o ^ 8'hA5;
  always #5 core_clk_i = ~core_clk_i;

  hcp_port dut (.core_clk_i, .nrst_i, .hw_rst_n_i, .cs_n_i, .sclk_i, .serial_in_line_i,
    .strobe_or_read_n_i, .output_edge_select_i, .port_par_sel_i, .strobe_style_select_i,
    .addr_i, .data_i, .data_o, .data_oe_n_o, .serial_out_line_o, .serial_out_oe_n_o,
    .reg_addr_o, .reg_wdata_o, .reg_wr_o, .reg_rd_o, .reg_rdata_i, .port_mode_o);

  hcp_host_model host (.core_clk_i, .style_i(strobe_style_select_i), .bus_i(data_i),
    .oe_n_i(data_oe_n_o), .sdo_i(serial_out_line_o), .cs_n_o(cs_n_i), .sclk_o(sclk_i),
    .sio_o(serial_in_line_i), .strb_n_o(strobe_or_read_n_i), .addr_o(addr_i), .data_o(host_d));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic chk_acc(input hcp_note_s got, input hcp_note_s exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: access got %h expected %h", $time, got, exp);
    end
  endtask : chk_acc

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: value got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Pops the oldest note on every register strobe; none may be unexpected
  // Sampled mid-cycle so the one-cycle pulses are settled when looked at
  always @(negedge core_clk_i)
  begin
    if (reg_wr_o === 1'b1 || reg_rd_o === 1'b1)
    begin
      if (notes.size() == 0)
      begin
        bad_count++;
        $display("CHECK FAILED at %0t: unexpected register access", $time);
      end
      else
      begin
        n = notes.pop_front();
        got_n = '{reg_wr_o, reg_addr_o, reg_wr_o ? reg_wdata_o : n.d};
        chk_acc(got_n, n);
      end
    end
  end

  task automatic set_mode(input logic par, input logic sty, input hcp_mode_e m);
    port_par_sel_i = par;
    strobe_style_select_i = sty;
    repeat (6) @(negedge core_clk_i);
    chk_val(8'(port_mode_o), 8'(m));
  endtask : set_mode

  // One access with random address and data
  task automatic acc(input logic ser, input logic rd, input logic es, input logic cs_en);
    logic [7:0] a, d, q;
    logic       oe;
    seed = xs(seed);
    a = seed[7:0];
    d = seed[15:8];
    oe = 1'b1;
    output_edge_select_i = es;
    if (cs_en) notes.push_back('{!rd, a, d});
    if (ser) host.ser(rd, es, a, d, q);
    else host.par(rd, cs_en, a, d, q, oe);
    if (rd && cs_en) chk_val(q, a ^ 8'hA5);
    if (!ser) chk_val({7'h00, oe}, {7'h00, !(rd && cs_en)});
    chk_val({7'h00, serial_out_oe_n_o}, 8'h01);
  endtask : acc

  initial
  begin
    repeat (3) @(negedge core_clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    set_mode(1'b0, 1'b0, HCP_SER);
    for (int i = 0; i < 4; i++) acc(1'b1, i[0], i[1], 1'b1);
    $display("serial frames done");
    // Strap flipped in mid-frame must not change the port
    fork
      acc(1'b1, 1'b1, 1'b0, 1'b1);
      begin
        repeat (40) @(negedge core_clk_i);
        port_par_sel_i = 1'b1;
        repeat (6) @(negedge core_clk_i);
        chk_val(8'(port_mode_o), 8'(HCP_SER));
        port_par_sel_i = 1'b0;
      end
    join
    $display("strap freeze done");
    for (int s = 0; s < 2; s++)
    begin
      set_mode(1'b1, s[0], s[0] ? HCP_PAR_RW : HCP_PAR_DS);
      for (int i = 0; i < 6; i++) acc(1'b0, i[0], 1'b0, i < 4);
      $display("parallel style %0d done", s);
    end
    // Short reset pulse ignored, long one resets the port
    for (int len = 5; len <= 20; len += 15)
    begin
      hw_rst_n_i = 1'b0;
      repeat (len) @(negedge core_clk_i);
      chk_val(8'(port_mode_o), 8'(len > 10 ? HCP_SER : HCP_PAR_RW));
      hw_rst_n_i = 1'b1;
      repeat (4) @(negedge core_clk_i);
      set_mode(1'b1, 1'b1, HCP_PAR_RW);
      acc(1'b0, 1'b1, 1'b0, 1'b1);
      $display("reset pulse %0d done", len);
    end
    chk_val(8'(notes.size()), 8'h00);
    report_and_stop();
  end

  // Watchdog against a hung handshake
  initial
  begin
    #(WATCH_NS);
    bad_count++;
    report_and_stop();
  end
endmodule : host_control_port_select_tb
`default_nettype wire
